/* File: rtl/ach_device.sv */
// converter-side control: start, busy, reset and calibration, power modes, read gating
// assumes every link input is asynchronous to mclk; the analog result arrives on analogCode
// How it works
// R1 - parallel mode: bit eleven carries result bit
// R2 - bits twelve to fifteen on parallel pins
// R3 - serial slave: bit eleven is read error
// R4 - serial slave: unfinished read at completion: drop, pulse flag
// R5 - busy rises when conversion starts
// R6 - busy falls once result is latched
// R7 - host takes busy fall as ready
// R8 - drivers on only with select, read low; bit eleven in serial slave mode is driven always
// R9 - select gates the slave serial clock
// R10 - reset pin high aborts, holds idle
// R11 - reset fall runs calibration, busy high
// R12 - power down: finish, then refuse starts
// R13 - start fall holds sample, begins conversion
// R14 - reference power down low: internal reference
// R15 - buffer power down low: buffer on
// R16 - serial mode: result out msb first
// R17 - clock source high: host drives clock
// R18 - after abort: busy low, no result
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ach_device
	import ach_pkg::*;
#(
	parameter int ConvCycles = CONV_CYCLES,
	parameter int CalCycles = CAL_CYCLES,
	parameter int MasterHalf = MASTER_SCLK_HALF,
	parameter int ErrCycles = RDERR_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	ach_if.dev link,
	input wire logic [RES_W-1:0] analogCode,
	output logic internalRefOn,
	output logic refBufferOn,
	output logic lowPower,
	output logic calibrating
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [9:0] pinRaw;
	logic [9:0] pinSync;
	logic startNS;
	logic csNS;
	logic rdNS;
	logic rstS;
	logic pwrS;
	logic refPwrS;
	logic bufPwrS;
	logic serialS;
	logic slaveS;
	logic hostSclkS;

	assign pinRaw = {link.convStartN, link.csN, link.rdN, link.converterReset, link.converterPowerDown,
		link.referencePowerDown, link.bufferPowerDown, link.serialParallelSelect,
		link.serialClockSourceSelect, link.hostSclk};

	ach_sync #(.Width(10), .ResetVal(DEV_SYNC_RST)) pinSyncU (
		.mclk(mclk),
		.srst(srst),
		.din(pinRaw),
		.dout(pinSync)
	);

	assign {startNS, csNS, rdNS, rstS, pwrS, refPwrS, bufPwrS, serialS, slaveS, hostSclkS} = pinSync;

	function automatic logic [3:0] msbIndex(input logic [4:0] n);
		msbIndex = 4'(RES_W - 1 - int'(n));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// edge history
	logic startPrevQ;
	logic rstPrevQ;
	logic gatedPrevQ;

	always_ff @(posedge mclk) begin
		if (srst) begin
			startPrevQ <= 1'b1;
			rstPrevQ <= 1'b0;
			gatedPrevQ <= 1'b0;
		end else begin
			startPrevQ <= startNS;
			rstPrevQ <= rstS;
			gatedPrevQ <= hostSclkS && !csNS;
		end
	end

	ach_dev_state_t stateQ;
	logic [7:0] timerQ;
	logic [4:0] bitCntQ;
	logic [RES_W-1:0] holdQ;
	logic [RES_W-1:0] resultQ;
	logic busyQ;
	logic startFall;
	logic rstFall;
	logic convBegin;
	logic convDone;
	logic rdEn;
	logic gatedSclk;
	logic slaveRise;
	logic readBusy;
	logic masterTick;
	logic phaseQ;
	logic shiftEvt;

	assign startFall = startPrevQ && !startNS;
	assign rstFall = rstPrevQ && !rstS;
	assign rdEn = !csNS && !rdNS;
	assign gatedSclk = hostSclkS && !csNS; // [R9]
	assign slaveRise = gatedSclk && !gatedPrevQ; // [R17]
	assign convBegin = (stateQ == S_IDLE) && startFall && !pwrS && !rstFall; // [R12] [R13]
	assign convDone = (stateQ == S_CONV) && (timerQ == 8'h00);
	// a slave read counts as begun once one bit has moved and not all sixteen
	assign readBusy = serialS && slaveS && rdEn && (bitCntQ != 5'h00) && (bitCntQ != 5'(RES_W));

	////////////////////////////////////////////////////////////////////////////
	// conversion and calibration sequencer
	always_ff @(posedge mclk) begin
		if (srst || rstS) begin
			stateQ <= S_IDLE; // [R10]
			timerQ <= 8'h00;
			busyQ <= 1'b0; // [R18]
		end else begin
			case (stateQ)
				S_IDLE: begin
					if (rstFall) begin
						stateQ <= S_CAL; // [R11]
						timerQ <= 8'(CalCycles - 1);
						busyQ <= 1'b1; // [R11]
					end else if (convBegin) begin
						stateQ <= S_CONV;
						timerQ <= 8'(ConvCycles - 1);
						busyQ <= 1'b1; // [R5]
					end
				end
				S_CONV, S_CAL: begin
					if (timerQ == 8'h00) begin
						stateQ <= S_IDLE;
						busyQ <= 1'b0; // [R6] [R7]
					end else begin
						timerQ <= timerQ - 8'h01;
					end
				end
				default: begin
					stateQ <= S_IDLE;
					busyQ <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sample hold and result latch
	always_ff @(posedge mclk) begin
		if (srst) begin
			holdQ <= '0;
		end else if (convBegin) begin
			holdQ <= analogCode; // [R13]
		end
	end

	// the aborted sample never reaches the result, which is cleared
	always_ff @(posedge mclk) begin
		if (srst || rstS) begin
			resultQ <= '0; // [R18]
		end else if (convDone && !readBusy) begin
			resultQ <= holdQ; // [R6]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// incomplete read flag
	logic [7:0] errCntQ;

	always_ff @(posedge mclk) begin
		if (srst || rstS) begin
			errCntQ <= 8'h00;
		end else if (convDone && readBusy) begin
			errCntQ <= 8'(ErrCycles); // [R4]
		end else if (errCntQ != 8'h00) begin
			errCntQ <= errCntQ - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial clock master and shifter
	logic [7:0] divQ;
	logic sclkQ;

	assign masterTick = (divQ == 8'h00);
	assign shiftEvt = serialS && rdEn && (bitCntQ < 5'(RES_W)) && (slaveS ? slaveRise : (masterTick && !phaseQ));

	// master mode: data moves on the falling edge so the host sees it stable on the rising one; in slave mode it moves on the rising edge
	always_ff @(posedge mclk) begin
		if (srst || !rdEn || !serialS || slaveS) begin
			divQ <= 8'(MasterHalf - 1);
			phaseQ <= 1'b0;
			sclkQ <= 1'b0;
		end else if (masterTick) begin
			divQ <= 8'(MasterHalf - 1);
			if (!phaseQ) begin
				sclkQ <= 1'b0;
				phaseQ <= (bitCntQ < 5'(RES_W));
			end else begin
				sclkQ <= 1'b1;
				phaseQ <= 1'b0;
			end
		end else begin
			divQ <= divQ - 8'h01;
		end
	end

	logic sdoQ;

	always_ff @(posedge mclk) begin
		if (srst || !rdEn) begin
			bitCntQ <= 5'h00;
			sdoQ <= 1'b0;
		end else if (shiftEvt) begin
			sdoQ <= resultQ[msbIndex(bitCntQ)]; // [R16]
			bitCntQ <= bitCntQ + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output pins
	logic [RES_W-1:0] parDataQ;
	logic parOeQ;
	logic elevenOeQ;
	logic serialOeQ;
	logic sclkOeQ;
	logic eleven;

	assign eleven = serialS ? (slaveS && (errCntQ != 8'h00)) : resultQ[11]; // [R1] [R3]

	always_ff @(posedge mclk) begin
		if (srst) begin
			parDataQ <= '0;
			parOeQ <= 1'b0;
			elevenOeQ <= 1'b0;
			serialOeQ <= 1'b0;
			sclkOeQ <= 1'b0;
		end else begin
			parDataQ <= {resultQ[15:12], eleven, resultQ[10:0]}; // [R2]
			parOeQ <= rdEn && !serialS; // [R8]
			// the flag must be seen whenever it fires, not only during a read
			elevenOeQ <= serialS ? slaveS : rdEn; // [R3]
			serialOeQ <= rdEn && serialS; // [R8]
			sclkOeQ <= rdEn && serialS && !slaveS; // [R17]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power and reference status
	logic refOnQ;
	logic bufOnQ;
	logic lowPwrQ;
	logic calQ;

	always_ff @(posedge mclk) begin
		if (srst) begin
			refOnQ <= 1'b0;
			bufOnQ <= 1'b0;
			lowPwrQ <= 1'b0;
			calQ <= 1'b0;
		end else begin
			refOnQ <= !refPwrS; // [R14]
			bufOnQ <= !bufPwrS; // [R15]
			lowPwrQ <= pwrS && (stateQ == S_IDLE); // [R12]
			calQ <= (stateQ == S_CAL);
		end
	end

	assign link.busy = busyQ;
	assign link.parData = parDataQ;
	assign link.parDataOe = parOeQ;
	assign link.bitElevenOe = elevenOeQ;
	assign link.serialResultOutput = sdoQ;
	assign link.serialOe = serialOeQ;
	assign link.devSclk = sclkQ;
	assign link.devSclkOe = sclkOeQ;
	assign internalRefOn = refOnQ;
	assign refBufferOn = bufOnQ;
	assign lowPower = lowPwrQ;
	assign calibrating = calQ;
endmodule
`default_nettype wire

/* File: rtl/ach_pkg.sv */
// shared constants, register map and state types of the converter control block
// assumes a 40 MHz mclk on both ends and a plain word-wide register port on the host
package ach_pkg;
	localparam int RES_W = 16;
	localparam int MCLK_MHZ = 40;

	// timing, in ns as given, then in mclk cycles
	localparam int CONV_TIME_NS = 500;
	localparam int CAL_TIME_NS = 1000;
	localparam int RDERR_TIME_NS = 100;
	localparam int CONV_CYCLES = (CONV_TIME_NS * MCLK_MHZ + 999) / 1000;
	localparam int CAL_CYCLES = (CAL_TIME_NS * MCLK_MHZ + 999) / 1000;
	localparam int RDERR_CYCLES = (RDERR_TIME_NS * MCLK_MHZ + 999) / 1000;

	// serial clock half periods and host strobe widths, in mclk cycles
	localparam int MASTER_SCLK_HALF = 4;
	localparam int HOST_SCLK_HALF = 8;
	localparam int START_LOW_CYCLES = 4;
	localparam int PAR_WAIT_CYCLES = 8;

	// reset value of the device pin synchroniser: start, select and read idle high
	localparam logic [9:0] DEV_SYNC_RST = 10'h380;

	// host register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_MASK = 4'h8;
	localparam logic [ADDR_W-1:0] REG_RESULT = 4'hc;

	// control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_RESET = 1;
	localparam int CTRL_PWRDN = 2;
	localparam int CTRL_REFPWR = 3;
	localparam int CTRL_BUFPWR = 4;
	localparam int CTRL_SERIAL = 5;
	localparam int CTRL_SLAVE = 6;
	localparam int CTRL_W = 7;
	localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 7'h00;

	// status and mask fields
	localparam int STAT_READY = 0;
	localparam int STAT_RDERR = 1;
	localparam int STAT_CALDONE = 2;
	localparam int STAT_W = 3;
	localparam int STAT_BUSY = 8;
	localparam logic [STAT_W-1:0] STAT_RST_VAL = 3'h0;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_CONV = 3'b010,
		S_CAL = 3'b100
	} ach_dev_state_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b01,
		H_READ = 2'b10
	} ach_host_state_t;
endpackage

/* File: rtl/ach_if.sv */
// pin bundle between the converter control logic and its host controller
// assumes the bench resolves bus levels from the enables; all pins are plain wires here
`timescale 1ns/1ps
`default_nettype none
interface ach_if;
	logic convStartN;
	logic csN;
	logic rdN;
	logic converterReset;
	logic converterPowerDown;
	logic referencePowerDown;
	logic bufferPowerDown;
	logic serialParallelSelect;
	logic serialClockSourceSelect;
	logic hostSclk;
	logic busy;
	// bit 11 has its own enable, it doubles as the incomplete read flag
	logic [15:0] parData;
	logic parDataOe;
	logic bitElevenOe;
	logic serialResultOutput;
	logic serialOe;
	logic devSclk;
	logic devSclkOe;

	modport dev (
		input convStartN, csN, rdN, converterReset, converterPowerDown, referencePowerDown,
		input bufferPowerDown, serialParallelSelect, serialClockSourceSelect, hostSclk,
		output busy, parData, parDataOe, bitElevenOe, serialResultOutput, serialOe, devSclk, devSclkOe
	);

	modport host (
		output convStartN, csN, rdN, converterReset, converterPowerDown, referencePowerDown,
		output bufferPowerDown, serialParallelSelect, serialClockSourceSelect, hostSclk,
		input busy, parData, parDataOe, bitElevenOe, serialResultOutput, serialOe, devSclk, devSclkOe
	);
endinterface
`default_nettype wire

/* File: rtl/ach_sync.sv */
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a level; multi-bit words must be stable while sampled
`timescale 1ns/1ps
`default_nettype none
module ach_sync #(
	parameter int Width = 1,
	parameter logic [Width-1:0] ResetVal = '0
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [Width-1:0] din,
	output logic [Width-1:0] dout
);
	logic [Width-1:0] metaQ;
	logic [Width-1:0] syncQ;

	// first stage feeds only the second one
	always_ff @(posedge mclk) begin
		if (srst) begin
			metaQ <= ResetVal;
			syncQ <= ResetVal;
		end else begin
			metaQ <= din;
			syncQ <= metaQ;
		end
	end

	assign dout = syncQ;
endmodule
`default_nettype wire

/* File: rtl/ach_host.sv */
// host controller: register port for software, drives the converter pins, reads results
// assumes device outputs are asynchronous to mclk; reads are started by the busy fall
`timescale 1ns/1ps
`default_nettype none
module ach_host
	import ach_pkg::*;
#(
	parameter int HostHalf = HOST_SCLK_HALF,
	parameter int StartLow = START_LOW_CYCLES,
	parameter int ParWait = PAR_WAIT_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	ach_if.host link,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRData,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// synchronisers and edges
	logic [18:0] pinSync;
	logic busyS;
	logic sdoS;
	logic sclkS;
	logic [RES_W-1:0] parS;
	logic busyPrevQ;
	logic sclkPrevQ;
	logic flagPrevQ;

	ach_sync #(.Width(19)) pinSyncU (
		.mclk(mclk),
		.srst(srst),
		.din({link.busy, link.serialResultOutput, link.devSclk, link.parData}),
		.dout(pinSync)
	);

	assign {busyS, sdoS, sclkS, parS} = pinSync;

	always_ff @(posedge mclk) begin
		if (srst) begin
			busyPrevQ <= 1'b0;
			sclkPrevQ <= 1'b0;
			flagPrevQ <= 1'b0;
		end else begin
			busyPrevQ <= busyS;
			sclkPrevQ <= sclkS;
			flagPrevQ <= parS[11];
		end
	end

	logic busyFall;
	logic sclkRise;
	logic flagRise;
	logic ctrlWr;

	assign busyFall = busyPrevQ && !busyS; // [R7]
	assign sclkRise = sclkS && !sclkPrevQ;
	assign flagRise = parS[11] && !flagPrevQ;
	assign ctrlWr = regWr && (regAddr == REG_CTRL);

	////////////////////////////////////////////////////////////////////////////
	// control register and start strobe
	logic [CTRL_W-1:0] ctrlQ;
	logic [7:0] startCntQ;
	logic startNQ;
	logic pendingQ;

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrlQ <= CTRL_RST_VAL;
		end else if (ctrlWr) begin
			ctrlQ <= regWData[CTRL_W-1:0];
			ctrlQ[CTRL_START] <= 1'b0;
			// internal reference needs the buffer, so it cannot be switched off alone
			ctrlQ[CTRL_BUFPWR] <= regWData[CTRL_BUFPWR] && regWData[CTRL_REFPWR]; // [R15]
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			startCntQ <= 8'h00;
			startNQ <= 1'b1;
		end else if (ctrlWr && regWData[CTRL_START] && (startCntQ == 8'h00)) begin
			startCntQ <= 8'(StartLow);
			startNQ <= 1'b0;
		end else if (startCntQ != 8'h00) begin
			startCntQ <= startCntQ - 8'h01;
			startNQ <= (startCntQ == 8'h01);
		end
	end

	// a busy fall with no start pending ends a calibration
	always_ff @(posedge mclk) begin
		if (srst || ctrlQ[CTRL_RESET]) begin
			pendingQ <= 1'b0;
		end else if (startCntQ == 8'h01) begin
			pendingQ <= 1'b1;
		end else if (busyFall) begin
			pendingQ <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// result reader
	ach_host_state_t hStateQ;
	logic [7:0] cntQ;
	logic [4:0] bitCntQ;
	logic [RES_W-1:0] shiftQ;
	logic [RES_W-1:0] resultQ;
	logic csNQ;
	logic rdNQ;
	logic hSclkQ;
	logic doneQ;
	logic errQ;

	always_ff @(posedge mclk) begin
		if (srst) begin
			hStateQ <= H_IDLE;
			cntQ <= 8'h00;
			bitCntQ <= 5'h00;
			shiftQ <= '0;
			resultQ <= '0;
			csNQ <= 1'b1;
			rdNQ <= 1'b1;
			hSclkQ <= 1'b0;
			doneQ <= 1'b0;
			errQ <= 1'b0;
		end else begin
			doneQ <= 1'b0;
			errQ <= 1'b0;
			case (hStateQ)
				H_IDLE: begin
					hSclkQ <= 1'b0;
					if (busyFall && pendingQ) begin
						hStateQ <= H_READ;
						csNQ <= 1'b0; // [R8]
						rdNQ <= 1'b0; // [R8]
						bitCntQ <= 5'h00;
						cntQ <= ctrlQ[CTRL_SERIAL] ? 8'(HostHalf - 1) : 8'(ParWait - 1);
					end
				end
				H_READ: begin
					if (!ctrlQ[CTRL_SERIAL]) begin
						if (cntQ == 8'h00) begin
							resultQ <= parS;
							doneQ <= 1'b1;
							hStateQ <= H_IDLE;
							csNQ <= 1'b1;
							rdNQ <= 1'b1;
						end else begin
							cntQ <= cntQ - 8'h01;
						end
					end else if (ctrlQ[CTRL_SLAVE] && flagRise) begin
						errQ <= 1'b1; // [R4]
						hStateQ <= H_IDLE;
						csNQ <= 1'b1;
						rdNQ <= 1'b1;
					end else if (ctrlQ[CTRL_SLAVE] ? (cntQ == 8'h00) : sclkRise) begin
						cntQ <= 8'(HostHalf - 1);
						if (ctrlQ[CTRL_SLAVE]) begin
							hSclkQ <= !hSclkQ; // [R17]
						end
						// slave samples at own falling edge, master at the rising edge seen
						if (!ctrlQ[CTRL_SLAVE] || hSclkQ) begin
							shiftQ <= {shiftQ[RES_W-2:0], sdoS}; // [R16]
							bitCntQ <= bitCntQ + 5'h01;
							if (bitCntQ == 5'(RES_W - 1)) begin
								resultQ <= {shiftQ[RES_W-2:0], sdoS};
								doneQ <= 1'b1;
								hStateQ <= H_IDLE;
								csNQ <= 1'b1;
								rdNQ <= 1'b1;
							end
						end
					end else if (ctrlQ[CTRL_SLAVE]) begin
						cntQ <= cntQ - 8'h01;
					end
				end
				default: begin
					hStateQ <= H_IDLE;
					csNQ <= 1'b1;
					rdNQ <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status, mask, interrupt and read port
	logic [STAT_W-1:0] statusQ;
	logic [STAT_W-1:0] maskQ;
	logic [STAT_W-1:0] setVec;
	logic [STAT_W-1:0] clrVec;
	logic irqQ;
	logic [DATA_W-1:0] rDataQ;

	assign setVec = {busyFall && !pendingQ, errQ, doneQ};
	assign clrVec = (regWr && (regAddr == REG_STATUS)) ? regWData[STAT_W-1:0] : '0;

	// set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			statusQ <= STAT_RST_VAL;
			maskQ <= STAT_RST_VAL;
			irqQ <= 1'b0;
		end else begin
			statusQ <= (statusQ & ~clrVec) | setVec;
			if (regWr && (regAddr == REG_MASK)) begin
				maskQ <= regWData[STAT_W-1:0];
			end
			irqQ <= |(statusQ & maskQ);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || !regRd) begin
			rDataQ <= '0;
		end else begin
			case (regAddr)
				REG_CTRL: rDataQ <= DATA_W'(ctrlQ);
				REG_STATUS: rDataQ <= DATA_W'({busyS, 5'h00, statusQ});
				REG_MASK: rDataQ <= DATA_W'(maskQ);
				REG_RESULT: rDataQ <= DATA_W'(resultQ);
				default: rDataQ <= '0;
			endcase
		end
	end

	assign link.convStartN = startNQ; // [R13]
	assign link.csN = csNQ;
	assign link.rdN = rdNQ;
	assign link.converterReset = ctrlQ[CTRL_RESET];
	assign link.converterPowerDown = ctrlQ[CTRL_PWRDN];
	assign link.referencePowerDown = ctrlQ[CTRL_REFPWR]; // [R14]
	assign link.bufferPowerDown = ctrlQ[CTRL_BUFPWR];
	assign link.serialParallelSelect = ctrlQ[CTRL_SERIAL];
	assign link.serialClockSourceSelect = ctrlQ[CTRL_SLAVE];
	assign link.hostSclk = hSclkQ;
	assign regRData = rDataQ;
	assign irq = irqQ;
endmodule
`default_nettype wire

/* File: sim/ach_link_chk.sv */
// link checker: watches the pins between the converter control and its host
// assumes both ends run on mclk and srst; instantiated beside the link in the bench
`timescale 1ns/1ps
`default_nettype none
module ach_link_chk
	import ach_pkg::*;
#(
	parameter int ConvCycles = CONV_CYCLES,
	parameter int CalCycles = CAL_CYCLES,
	parameter int ErrCycles = RDERR_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic convStartN,
	input wire logic csN,
	input wire logic converterReset,
	input wire logic converterPowerDown,
	input wire logic serialParallelSelect,
	input wire logic serialClockSourceSelect,
	input wire logic busy,
	input wire logic [15:0] parData,
	input wire logic parDataOe,
	input wire logic bitElevenOe,
	input wire logic serialResultOutput,
	input wire logic serialOe,
	input wire logic devSclkOe
);
////////////////////////////////////////////////////////////////////////////////
logic [11:0] busyCnt_q;
logic [11:0] flagCnt_q;
logic abort_q;
logic slaveMode;
assign slaveMode = serialParallelSelect && serialClockSourceSelect;
always_ff @(posedge mclk) begin
	if (srst || !busy) begin
		busyCnt_q <= 12'h000;
	end else begin
		busyCnt_q <= busyCnt_q + 12'h001;
	end
end
always_ff @(posedge mclk) begin
	if (srst || !(parData[11] && slaveMode)) begin
		flagCnt_q <= 12'h000;
	end else begin
		flagCnt_q <= flagCnt_q + 12'h001;
	end
end
// an aborted conversion has a short busy, excused until calibration starts
always_ff @(posedge mclk) begin
	if (srst) begin
		abort_q <= 1'b0;
	end else if (converterReset) begin
		abort_q <= 1'b1;
	end else if (busy && busyCnt_q == 12'h000) begin
		abort_q <= 1'b0;
	end
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (srst);
busy_span_a: assert property ($fell(busy) && !abort_q |-> busyCnt_q == ConvCycles || busyCnt_q == CalCycles)
	else $error("busy high for a wrong span");
start_busy_a: assert property ($fell(convStartN) && !busy && !converterPowerDown && !converterReset && !abort_q
	|-> ##[1:5] busy) else $error("start did not raise busy");
powerdown_refuse_a: assert property ((converterPowerDown && !busy)[*6] ##1 $fell(convStartN) && converterPowerDown
	|=> !busy[*8]) else $error("start taken in power down");
reset_abort_a: assert property (converterReset[*5] |-> !busy) else $error("busy high in reset");
reset_cal_a: assert property ($fell(converterReset) |-> ##[1:6] busy) else $error("no calibration pulse");
oe_gate_a: assert property (csN[*6] |-> !parDataOe && !serialOe) else $error("driver on without select");
par_bit_a: assert property (!serialParallelSelect && $past(serialParallelSelect, 4) == 1'b0 && parDataOe
	|-> bitElevenOe) else $error("bit eleven not driven");
slave_oe_a: assert property (slaveMode && $past(slaveMode, 4) |-> bitElevenOe) else $error("flag not driven");
flag_len_a: assert property ($fell(parData[11]) && slaveMode && $past(slaveMode, 4)
	|-> flagCnt_q == ErrCycles) else $error("read error pulse length wrong");
master_clk_a: assert property (serialClockSourceSelect[*4] |-> !devSclkOe) else $error("clock driven in slave");
slave_gate_a: assert property ((csN && serialClockSourceSelect && !busy)[*6] |-> $stable(serialResultOutput))
	else $error("serial data moved without select");
conv_c: cover property ($fell(busy) && busyCnt_q == ConvCycles);
cal_c: cover property ($fell(busy) && busyCnt_q == CalCycles);
flag_c: cover property ($fell(parData[11]) && slaveMode);
endmodule
`default_nettype wire

/* File: sim/ach_tb.sv */
// bench: host register port drives conversions through both ends of the link
// assumes the package register map; the analog code is a plain bench input
`timescale 1ns/1ps
`default_nettype none
module ach_tb
	import ach_pkg::*;
;
typedef struct packed {logic [6:0] ctrl; logic [15:0] code; logic refOn; logic bufOn;} ach_row_t;
logic mclk;
logic srst;
logic [ADDR_W-1:0] regAddr;
logic [DATA_W-1:0] regWData;
logic regWr;
logic regRd;
logic [DATA_W-1:0] regRData;
logic irq;
logic [RES_W-1:0] analogCode;
logic internalRefOn;
logic refBufferOn;
logic lowPower;
logic calibrating;
int error_cnt = 0;
int n_compared = 0;
ach_row_t rows [3];
ach_if linkIf();
ach_device ach_device_inst (.mclk(mclk), .srst(srst), .link(linkIf), .analogCode(analogCode),
	.internalRefOn(internalRefOn), .refBufferOn(refBufferOn), .lowPower(lowPower), .calibrating(calibrating));
ach_host ach_host_inst (.mclk(mclk), .srst(srst), .link(linkIf), .regAddr(regAddr), .regWData(regWData),
	.regWr(regWr), .regRd(regRd), .regRData(regRData), .irq(irq));
ach_link_chk ach_link_chk_inst (.mclk(mclk), .srst(srst), .convStartN(linkIf.convStartN), .csN(linkIf.csN),
	.converterReset(linkIf.converterReset), .converterPowerDown(linkIf.converterPowerDown),
	.serialParallelSelect(linkIf.serialParallelSelect), .serialClockSourceSelect(linkIf.serialClockSourceSelect),
	.busy(linkIf.busy), .parData(linkIf.parData), .parDataOe(linkIf.parDataOe), .bitElevenOe(linkIf.bitElevenOe),
	.serialResultOutput(linkIf.serialResultOutput), .serialOe(linkIf.serialOe), .devSclkOe(linkIf.devSclkOe));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
	n_compared++;
	if (seen !== exp) begin
		error_cnt++;
		$display("Error %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic wr(input logic [3:0] a, input logic [31:0] d);
	@(posedge mclk);
	regAddr <= a;
	regWData <= d;
	regWr <= 1'b1;
	@(posedge mclk);
	regWr <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, output logic [31:0] d);
	@(posedge mclk);
	regAddr <= a;
	regRd <= 1'b1;
	@(posedge mclk);
	regRd <= 1'b0;
	#1 d = regRData;
endtask
// bounded poll: a stuck status bit shows up as one mismatch, not a hang
task automatic waitBit(input int b);
	logic [31:0] s;
	s = 32'h0;
	for (int n = 0; n < 800 && s[b] !== 1'b1; n++) rd(REG_STATUS, s);
	chk("status bit", {31'h0, s[b]}, 32'h1);
endtask
task automatic report_and_stop();
	if (error_cnt == 0 && n_compared > 0) begin
		$display("[ PASS ]");
	end else begin
		$display("[ FAIL ]");
	end
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	mclk = 1'b0;
	forever #12.5 mclk = ~mclk;
end
initial begin
	repeat (40000) @(posedge mclk);
	error_cnt++;
	report_and_stop();
end
initial begin
	logic [31:0] v;
	srst = 1'b1;
	regAddr = 4'h0;
	regWData = 32'h0;
	regWr = 1'b0;
	regRd = 1'b0;
	analogCode = 16'h0000;
	rows[0] = {7'h00, 16'h0800, 2'b11};
	rows[1] = {7'h28, 16'ha5c3, 2'b01};
	rows[2] = {7'h78, 16'hf00f, 2'b00};
	repeat (2) @(posedge mclk);
	srst <= 1'b0;
	for (int a = 0; a < 16; a++) begin
		rd(a[3:0], v);
		chk("reset read", v, 32'h0);
	end
	wr(REG_MASK, 32'h1);
	for (int i = 0; i < 3; i++) begin
		@(posedge mclk);
		analogCode <= rows[i].code;
		wr(REG_CTRL, {25'h0, rows[i].ctrl | 7'h01});
		waitBit(STAT_READY);
		rd(REG_RESULT, v);
		chk("result", v, {16'h0, rows[i].code});
		rd(REG_CTRL, v);
		chk("ctrl", v, {25'h0, rows[i].ctrl});
		chk("ref on", {31'h0, internalRefOn}, {31'h0, rows[i].refOn});
		chk("buffer on", {31'h0, refBufferOn}, {31'h0, rows[i].bufOn});
		chk("low power off", {31'h0, lowPower}, 32'h0);
		chk("not calibrating", {31'h0, calibrating}, 32'h0);
		chk("irq set", {31'h0, irq}, 32'h1);
		wr(REG_STATUS, 32'h1);
		rd(REG_STATUS, v);
		chk("status clear", v, 32'h0);
		chk("irq clear", {31'h0, irq}, 32'h0);
	end
	// reset in mid conversion, then calibration on its release
	wr(REG_CTRL, 32'h1);
	repeat (8) @(posedge mclk);
	wr(REG_CTRL, 32'h2);
	repeat (10) @(posedge mclk);
	rd(REG_STATUS, v);
	chk("busy in reset", {31'h0, v[STAT_BUSY]}, 32'h0);
	// the aborted busy fall already flagged calibration done, so clear it first
	wr(REG_STATUS, 32'h7);
	wr(REG_CTRL, 32'h0);
	repeat (8) @(posedge mclk);
	chk("calibrating", {31'h0, calibrating}, 32'h1);
	waitBit(STAT_CALDONE);
	// power down right behind a start: that one ends, the next is refused
	wr(REG_STATUS, 32'h7);
	wr(REG_MASK, 32'h0);
	wr(REG_CTRL, 32'h1);
	wr(REG_CTRL, 32'h4);
	waitBit(STAT_READY);
	chk("irq masked", {31'h0, irq}, 32'h0);
	chk("low power", {31'h0, lowPower}, 32'h1);
	wr(REG_STATUS, 32'h7);
	wr(REG_CTRL, 32'h5);
	repeat (60) @(posedge mclk);
	rd(REG_STATUS, v);
	chk("refused start", v, 32'h0);
	// slave read still shifting when the next conversion ends
	wr(REG_CTRL, 32'h61);
	repeat (60) @(posedge mclk);
	wr(REG_CTRL, 32'h61);
	waitBit(STAT_RDERR);
	repeat (400) @(posedge mclk);
	report_and_stop();
end
endmodule
`default_nettype wire
